/* rtl/pbws_sequencer.v */
// pbws_sequencer.v: system power state sequencer on the standby domain.
// assumes all pins are asynchronous; rst_n low holds the block in boot.
// Operation
// [R1] short press: off to on, on to sleep, sleep to on.
// [R2] press held past long threshold in on or sleep forces soft-off.
// [R3] press between thresholds causes nothing once released.
// [R4] switch, rtc, lan, pme, pcie wake, keyboard wake from S3, S4, S5.
// [R5] usb and serial wake only from S3, ignored in S4 and S5.
// [R6] keyboard wake from S5 limited to chosen combo or power key.
// [R7] power-off command drops main rails, standby rail stays on.
// [R8] after ac return restore the last on or off state.
// [R9] stored restore policy overrides last-state default.
// [R10] pme wakes only while wake-on-pme option enabled.
`timescale 1ns/1ps
`default_nettype none
`include "pbws_defs.vh"

module pbws_sequencer #(
	parameter [`PBWS_CNT_W-1:0] SHORT_CYC = `PBWS_SHORT_CYC,
	parameter [`PBWS_CNT_W-1:0] LONG_CYC  = `PBWS_LONG_CYC
) (
	input  wire                     sys_clk,
	input  wire                     rst_n,
	input  wire                     pwr_btn_n,
	input  wire [`PBWS_WK_N-1:0]    wake_req,
	input  wire                     sleep_cmd,
	input  wire                     sleep_s4,
	input  wire                     off_cmd,
	input  wire [1:0]               restore_policy,
	input  wire                     pme_wake_en,
	input  wire                     kbd_s5_pkey_sel,
	input  wire                     last_on_saved,
	output reg                      main_rails_on,
	output reg                      standby_on,
	output reg  [`PBWS_ST_W-1:0]    sys_state,
	output reg                      last_on_store,
	output reg                      wake_event
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [4:0] ST_BOOT = 5'b00001;
	localparam [4:0] ST_S0   = 5'b00010;
	localparam [4:0] ST_S3   = 5'b00100;
	localparam [4:0] ST_S4   = 5'b01000;
	localparam [4:0] ST_S5   = 5'b10000;

	reg  [4:0]                  st_q;
	reg  [4:0]                  st_d;

	// ----------------------------------------------------------------
	// synchronisers: first stage read only by second stage
	// ----------------------------------------------------------------
	localparam SYN_N = `PBWS_WK_N + 5;
	wire [SYN_N-1:0]            raw;
	reg  [SYN_N-1:0]            syn1_q;
	reg  [SYN_N-1:0]            syn2_q;

	assign raw = {~pwr_btn_n, sleep_cmd, sleep_s4, off_cmd, kbd_s5_pkey_sel, wake_req};

	genvar gi;
	generate
		for (gi = 0; gi < SYN_N; gi = gi + 1) begin : g_sync
			always @(posedge sys_clk) begin
				if (!rst_n) begin
					syn1_q[gi] <= 1'b0;
					syn2_q[gi] <= 1'b0;
				end else begin
					syn1_q[gi] <= raw[gi];
					syn2_q[gi] <= syn1_q[gi];
				end
			end
		end
	endgenerate

	// config straps move slowly; two flops each as well
	// boot waits on its counter, else restore would read the flushed reset zeros
	reg  [1:0]                  cfg1_q;
	reg  [1:0]                  cfg2_q;
	reg  [1:0]                  pol1_q;
	reg  [1:0]                  pol2_q;
	reg  [1:0]                  boot_cnt_q;
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			cfg1_q     <= 2'h0;
			cfg2_q     <= 2'h0;
			pol1_q     <= 2'h0;
			pol2_q     <= 2'h0;
			boot_cnt_q <= 2'h0;
		end else begin
			cfg1_q <= {pme_wake_en, last_on_saved};
			cfg2_q <= cfg1_q;
			pol1_q <= restore_policy;
			pol2_q <= pol1_q;
			if (st_q == ST_BOOT && boot_cnt_q != `PBWS_BOOT_CYC)
				boot_cnt_q <= boot_cnt_q + 2'h1; // R8 R9
		end
	end

	wire [`PBWS_WK_N-1:0]       wk      = syn2_q[`PBWS_WK_N-1:0];
	wire                        pkey    = syn2_q[`PBWS_WK_N];
	wire                        off_s   = syn2_q[`PBWS_WK_N+1];
	wire                        s4_s    = syn2_q[`PBWS_WK_N+2];
	wire                        slp_s   = syn2_q[`PBWS_WK_N+3];
	wire                        btn_s   = syn2_q[`PBWS_WK_N+4];
	wire                        pme_en  = cfg2_q[1];
	wire                        last_on = cfg2_q[0];

	// sleep and off commands act on their rising edge only
	reg                         slp_prev_q;
	reg                         off_prev_q;
	wire                        slp_rise = slp_s & ~slp_prev_q;
	wire                        off_rise = off_s & ~off_prev_q;

	// ----------------------------------------------------------------
	// press classifier
	// ----------------------------------------------------------------
	wire                        short_p;
	wire                        long_p;

	pbws_press_timer #(
		.SHORT_CYC (SHORT_CYC),
		.LONG_CYC  (LONG_CYC)
	) u_press (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.press_lvl   (btn_s),
		.short_pulse (short_p),
		.long_pulse  (long_p)
	);

	// ----------------------------------------------------------------
	// wake qualification per state
	// ----------------------------------------------------------------
	wire kbd_ok_s5 = pkey ? wk[`PBWS_WK_KBD_PKEY] : wk[`PBWS_WK_KBD_COMBO]; // R6
	wire kbd_any   = wk[`PBWS_WK_KBD_PKEY] | wk[`PBWS_WK_KBD_COMBO];
	wire pme_ok    = wk[`PBWS_WK_PME] & pme_en; // R10
	wire wake_core = wk[`PBWS_WK_RTC] | wk[`PBWS_WK_LAN] | pme_ok
	               | wk[`PBWS_WK_PCIE]; // R4
	wire wake_s3   = wake_core | kbd_any | wk[`PBWS_WK_USB] | wk[`PBWS_WK_SER]; // R5
	// S4 keeps full keyboard wake; only S5 narrows to the selection
	wire wake_s4   = wake_core | kbd_any; // R5
	wire wake_s5   = wake_core | kbd_ok_s5; // R4 R6

	// ----------------------------------------------------------------
	// next state: long press outranks everything, then off command, then short press or wake, then sleep command
	// ----------------------------------------------------------------
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_BOOT: begin
				// policy first; last-state default when policy is neither on nor off
				if (boot_cnt_q == `PBWS_BOOT_CYC) begin
					if (pol2_q == `PBWS_POL_ON)
						st_d = ST_S0; // R9
					else if (pol2_q == `PBWS_POL_OFF)
						st_d = ST_S5; // R9
					else
						st_d = last_on ? ST_S0 : ST_S5; // R8
				end
			end
			ST_S0: begin
				if (long_p)
					st_d = ST_S5; // R2
				else if (off_rise)
					st_d = ST_S5; // R7
				else if (short_p)
					st_d = ST_S3; // R1
				else if (slp_rise)
					st_d = s4_s ? ST_S4 : ST_S3;
			end
			ST_S3: begin
				if (long_p)
					st_d = ST_S5; // R2
				else if (short_p || wake_s3)
					st_d = ST_S0; // R1 R4 R5
			end
			ST_S4: begin
				if (long_p)
					st_d = ST_S5; // R2
				else if (short_p || wake_s4)
					st_d = ST_S0; // R1 R4
			end
			ST_S5: begin
				if (short_p || wake_s5)
					st_d = ST_S0; // R1 R4
			end
			default: st_d = ST_S5;
		endcase
	end

	// ----------------------------------------------------------------
	// state register and registered outputs
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q          <= ST_BOOT;
			slp_prev_q    <= 1'b0;
			off_prev_q    <= 1'b0;
			main_rails_on <= 1'b0;
			standby_on    <= 1'b1;
			sys_state     <= `PBWS_ST_S5;
			last_on_store <= 1'b0;
			wake_event    <= 1'b0;
		end else begin
			st_q          <= st_d;
			slp_prev_q    <= slp_s;
			off_prev_q    <= off_s;
			standby_on    <= 1'b1; // R7
			main_rails_on <= (st_d == ST_S0); // R7
			// saved state follows the running state, not boot
			last_on_store <= (st_d == ST_BOOT) ? 1'b0 : (st_d == ST_S0); // R8
			wake_event    <= (st_q != ST_S0) && (st_q != ST_BOOT) && (st_d == ST_S0);
			case (st_d)
				ST_S0:   sys_state <= `PBWS_ST_S0;
				ST_S3:   sys_state <= `PBWS_ST_S3;
				ST_S4:   sys_state <= `PBWS_ST_S4;
				default: sys_state <= `PBWS_ST_S5;
			endcase
		end
	end

endmodule // pbws_sequencer

`default_nettype wire

/* pkg/pbws_defs.vh */
// pbws_defs.vh: constants for the power button and wake sequencer.
// assumes a 200 MHz standby clock; included by bare name.
`ifndef PBWS_DEFS_VH
`define PBWS_DEFS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define PBWS_CLK_MHZ          200
`define PBWS_SHORT_SEC        4
`define PBWS_LONG_SEC         6
`define PBWS_SHORT_CYC        (`PBWS_SHORT_SEC * `PBWS_CLK_MHZ * 1000000)
`define PBWS_LONG_CYC         (`PBWS_LONG_SEC * `PBWS_CLK_MHZ * 1000000)
`define PBWS_CNT_W            32
// cycles spent in boot so both strap flops hold pin values before restore
`define PBWS_BOOT_CYC         2'h2

// ----------------------------------------------------------------
// power state codes on sys_state
// ----------------------------------------------------------------
`define PBWS_ST_W             3
`define PBWS_ST_S0            3'h0
`define PBWS_ST_S3            3'h3
`define PBWS_ST_S4            3'h4
`define PBWS_ST_S5            3'h5

// ----------------------------------------------------------------
// restore policy after ac loss
// ----------------------------------------------------------------
`define PBWS_POL_LAST         2'h0
`define PBWS_POL_ON           2'h1
`define PBWS_POL_OFF          2'h2

// ----------------------------------------------------------------
// wake source bit positions
// ----------------------------------------------------------------
`define PBWS_WK_N             8
`define PBWS_WK_RTC           0
`define PBWS_WK_LAN           1
`define PBWS_WK_PME           2
`define PBWS_WK_PCIE          3
`define PBWS_WK_KBD_COMBO     4
`define PBWS_WK_KBD_PKEY      5
`define PBWS_WK_USB           6
`define PBWS_WK_SER           7

`endif

/* rtl/pbws_press_timer.v */
// pbws_press_timer.v: classifies a synchronised button press by length.
// assumes press_lvl already passed a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "pbws_defs.vh"

module pbws_press_timer #(
	parameter [`PBWS_CNT_W-1:0] SHORT_CYC = `PBWS_SHORT_CYC,
	parameter [`PBWS_CNT_W-1:0] LONG_CYC  = `PBWS_LONG_CYC
) (
	input  wire                 sys_clk,
	input  wire                 rst_n,
	input  wire                 press_lvl,
	output reg                  short_pulse,
	output reg                  long_pulse
);

	reg  [`PBWS_CNT_W-1:0]       cnt_q;
	reg                          prev_q;
	reg                          long_done_q;

	// count held time; long fires while held so a stuck switch still powers off
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q       <= {`PBWS_CNT_W{1'b0}};
			prev_q      <= 1'b0;
			long_done_q <= 1'b0;
			short_pulse <= 1'b0;
			long_pulse  <= 1'b0;
		end else begin
			prev_q      <= press_lvl;
			short_pulse <= 1'b0;
			long_pulse  <= 1'b0;
			if (press_lvl) begin
				if (cnt_q != {`PBWS_CNT_W{1'b1}})
					cnt_q <= cnt_q + 1'b1;
				if (cnt_q == LONG_CYC && !long_done_q) begin
					long_pulse  <= 1'b1; // R2
					long_done_q <= 1'b1;
				end
			end else begin
				cnt_q       <= {`PBWS_CNT_W{1'b0}};
				long_done_q <= 1'b0;
				// release: short only; middle band is dropped
				if (prev_q && cnt_q < SHORT_CYC)
					short_pulse <= 1'b1; // R1 R3
			end
		end
	end

endmodule // pbws_press_timer

`default_nettype wire

/* testbench/pbws_sequencer_properties.sv */
// pbws_sequencer_properties.sv: port assertions for the power sequencer.
// assumes one sys_clk domain; bound onto the top from the testbench.
`timescale 1ns/1ps
`default_nettype none
`include "pbws_defs.vh"
module pbws_sequencer_properties #(
	parameter [31:0] SHORT_CYC = 40,
	parameter [31:0] LONG_CYC  = 60
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       pwr_btn_n,
	input wire logic [7:0] wake_req,
	input wire logic       sleep_cmd,
	input wire logic       sleep_s4,
	input wire logic       off_cmd,
	input wire logic [1:0] restore_policy,
	input wire logic       pme_wake_en,
	input wire logic       kbd_s5_pkey_sel,
	input wire logic       last_on_saved,
	input wire logic       main_rails_on,
	input wire logic       standby_on,
	input wire logic [2:0] sys_state,
	input wire logic       last_on_store,
	input wire logic       wake_event
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
// working state seen as one flag
wire s0 = (sys_state == `PBWS_ST_S0);
property p_rails; main_rails_on == s0; endproperty
property p_stby; standby_on; endproperty
property p_pulse; wake_event |=> !wake_event; endproperty
property p_cause; wake_event |-> s0 && $past(sys_state) != `PBWS_ST_S0; endproperty
property p_store; last_on_store == s0; endproperty
// five quiet cycles cover the sync and press-timer latency
property p_usb; (sys_state == `PBWS_ST_S4 && pwr_btn_n && wake_req[5:0] == 6'h00)[*5]
	|=> sys_state == `PBWS_ST_S4; endproperty
property p_pme; (!s0 && !pme_wake_en && pwr_btn_n && (wake_req & 8'hfb) == 8'h00)[*5]
	|=> !s0; endproperty
property p_kbd; (sys_state == `PBWS_ST_S5 && kbd_s5_pkey_sel && pwr_btn_n
	&& (wake_req & 8'hef) == 8'h00)[*5] |=> sys_state == `PBWS_ST_S5; endproperty
a_rails: assert property (p_rails) else $error("rails differ from working state");
a_stby: assert property (p_stby) else $error("standby rail dropped");
a_pulse: assert property (p_pulse) else $error("wake pulse too long");
a_cause: assert property (p_cause) else $error("wake pulse without entry");
a_store: assert property (p_store) else $error("saved state wrong");
a_usb: assert property (p_usb) else $error("usb or serial woke deep sleep");
a_pme: assert property (p_pme) else $error("disabled pme woke");
a_kbd: assert property (p_kbd) else $error("unselected key woke soft-off");
c_wake: cover property (wake_event);
c_s4: cover property (sys_state == `PBWS_ST_S4);
c_s3: cover property (sys_state == `PBWS_ST_S3 ##1 s0);
endmodule // pbws_sequencer_properties
`default_nettype wire

/* testbench/pbws_far_side.sv */
// pbws_far_side.sv: switch, wake sources and supply beside the sequencer.
// assumes the testbench commands presses and wake levels.
`timescale 1ns/1ps
`default_nettype none
module pbws_far_side (
	input wire logic       sys_clk,
	input wire logic       press_req,
	input wire logic [7:0] wake_drive,
	input wire logic       main_rails_on,
	output logic           pwr_btn_n,
	output logic [7:0]     wake_req,
	output logic           rails_live
);
// ----------------------------------------
// pins
// ----------------------------------------
initial begin
	pwr_btn_n = 1'b1;
	wake_req = 8'h00;
	rails_live = 1'b0;
end
// wake lines fall while the rails are on; a source still driven rises again once they drop
always @(posedge sys_clk) begin
	pwr_btn_n <= ~press_req;
	wake_req <= wake_drive & {8{~main_rails_on}};
	rails_live <= main_rails_on;
end
endmodule // pbws_far_side
`default_nettype wire

/* testbench/pbws_sequencer_tb.sv */
// pbws_sequencer_tb.sv: self-checking bench for the power sequencer.
// assumes short and long thresholds cut to 40 and 60 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pbws_defs.vh"
module pbws_sequencer_tb;
logic       sys_clk, rst_n, press_req, sleep_cmd, sleep_s4, off_cmd, pme_wake_en;
logic       kbd_s5_pkey_sel, last_on_saved, pwr_btn_n, main_rails_on, standby_on;
logic       last_on_store, wake_event, rails_live;
logic [1:0] restore_policy;
logic [7:0] wake_drive, wake_req;
logic [2:0] sys_state;
int         errors, checked, cyc, wakes, w;
// start, expected, wake lines, pme enable, power-key select
logic [23:0] rows [14] = '{24'h50_0100, 24'h30_0200, 24'h40_0410, 24'h55_0400,
	24'h50_0800, 24'h30_4000, 24'h44_4000, 24'h55_8000, 24'h55_1001, 24'h50_2001,
	24'h40_1000, 24'h30_8000, 24'h50_1000, 24'h55_2000};
pbws_sequencer #(.SHORT_CYC(40), .LONG_CYC(60)) i_pbws_sequencer (.sys_clk(sys_clk),
	.rst_n(rst_n), .pwr_btn_n(pwr_btn_n), .wake_req(wake_req), .sleep_cmd(sleep_cmd),
	.sleep_s4(sleep_s4), .off_cmd(off_cmd), .restore_policy(restore_policy),
	.pme_wake_en(pme_wake_en), .kbd_s5_pkey_sel(kbd_s5_pkey_sel),
	.last_on_saved(last_on_saved), .main_rails_on(main_rails_on), .standby_on(standby_on),
	.sys_state(sys_state), .last_on_store(last_on_store), .wake_event(wake_event));
pbws_far_side i_pbws_far_side (.sys_clk(sys_clk), .press_req(press_req),
	.wake_drive(wake_drive), .main_rails_on(main_rails_on), .pwr_btn_n(pwr_btn_n),
	.wake_req(wake_req), .rails_live(rails_live));
// ----------------------------------------
// tasks
// ----------------------------------------
task automatic chks(input logic [2:0] g, input logic [2:0] e);
	checked++;
	if (g !== e) begin
		errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task automatic chkb(input logic g, input logic e);
	checked++;
	if (g !== e) begin
		errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task automatic press(input int n);
	press_req <= 1'b1;
	repeat (n) @(posedge sys_clk);
	press_req <= 1'b0;
	repeat (9) @(posedge sys_clk);
endtask
task automatic pulse(input logic s4, input logic off);
	sleep_s4 <= s4;
	sleep_cmd <= ~off;
	off_cmd <= off;
	repeat (4) @(posedge sys_clk);
	sleep_cmd <= 1'b0;
	off_cmd <= 1'b0;
	repeat (6) @(posedge sys_clk);
endtask
// ac loss: straps set during reset, restore decided a few cycles after release
task automatic reboot(input logic [1:0] pol, input logic lst, input logic [2:0] exp);
	rst_n <= 1'b0;
	restore_policy <= pol;
	last_on_saved <= lst;
	repeat (5) @(posedge sys_clk);
	rst_n <= 1'b1;
	repeat (4) @(posedge sys_clk);
	chks(sys_state, exp);
	chkb(main_rails_on, exp == `PBWS_ST_S0);
	$display("reboot test done");
endtask
task automatic tally_and_finish;
	$display("checked=%0d errors=%0d", checked, errors);
	if (errors == 0 && checked > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
// ----------------------------------------
// clock, timeout, sequence
// ----------------------------------------
initial begin
	sys_clk = 1'b0;
	forever #2.5 sys_clk = ~sys_clk;
end
// wake pulse lasts one cycle, so count it at every edge
always @(posedge sys_clk) begin
	if (wake_event === 1'b1) wakes <= wakes + 1;
end
// a hang counts as a mismatch
always @(posedge sys_clk) begin
	cyc++;
	if (cyc == 5000) begin
		errors++;
		tally_and_finish;
	end
end
initial begin
	{rst_n, press_req, sleep_cmd, sleep_s4, off_cmd, pme_wake_en} = 6'h00;
	{kbd_s5_pkey_sel, last_on_saved, restore_policy, wake_drive} = 12'h000;
	repeat (5) @(posedge sys_clk);
	rst_n <= 1'b1;
	repeat (4) @(posedge sys_clk);
	chks(sys_state, `PBWS_ST_S5);
	chkb(standby_on, 1'b1);
	$display("reset test done");
	for (int i = 0; i < 14; i++) begin
		pme_wake_en <= rows[i][4];
		kbd_s5_pkey_sel <= rows[i][0];
		press(10);
		if (rows[i][23:20] != 4'h5) pulse(rows[i][22], 1'b0);
		else pulse(1'b0, 1'b1);
		wake_drive <= rows[i][15:8];
		repeat (10) @(posedge sys_clk);
		chks(sys_state, rows[i][18:16]);
		wake_drive <= 8'h00;
		press(80);
		$display("row %0d done", i);
	end
	press(10);
	chks(sys_state, `PBWS_ST_S0);
	chkb(last_on_store, 1'b1);
	press(50);
	chks(sys_state, `PBWS_ST_S0);
	press(10);
	chks(sys_state, `PBWS_ST_S3);
	w = wakes;
	press(10);
	chks(sys_state, `PBWS_ST_S0);
	chkb(wakes == w + 1, 1'b1);
	press(10);
	press(80);
	chks(sys_state, `PBWS_ST_S5);
	press(10);
	pulse(1'b0, 1'b1);
	chkb(main_rails_on, 1'b0);
	chkb(rails_live, 1'b0);
	chkb(last_on_store, 1'b0);
	press(10);
	press(80);
	chks(sys_state, `PBWS_ST_S5);
	$display("press tests done");
	reboot(`PBWS_POL_ON, 1'b0, `PBWS_ST_S0);
	reboot(`PBWS_POL_LAST, last_on_store, `PBWS_ST_S0);
	reboot(`PBWS_POL_OFF, last_on_store, `PBWS_ST_S5);
	reboot(`PBWS_POL_LAST, last_on_store, `PBWS_ST_S5);
	tally_and_finish;
end
endmodule // pbws_sequencer_tb
bind pbws_sequencer pbws_sequencer_properties #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC))
	i_pbws_sequencer_properties (.sys_clk(sys_clk), .rst_n(rst_n), .pwr_btn_n(pwr_btn_n),
	.wake_req(wake_req), .sleep_cmd(sleep_cmd), .sleep_s4(sleep_s4), .off_cmd(off_cmd),
	.restore_policy(restore_policy), .pme_wake_en(pme_wake_en),
	.kbd_s5_pkey_sel(kbd_s5_pkey_sel), .last_on_saved(last_on_saved),
	.main_rails_on(main_rails_on), .standby_on(standby_on), .sys_state(sys_state),
	.last_on_store(last_on_store), .wake_event(wake_event));
`default_nettype wire
